// ---- logic/qdac_top.sv ----
// serial command interpreter of the quad dac
`timescale 1ns/10ps
`include "qdac_cfg.svh"
// Notes on behaviour
// - word is addr(2), ctrl(2), code(10), sub(2), msb first
// - each channel has input register then dac register; input register loaded only when named
// - ctrl 01 loads addressed input register only
// - ctrl 11 loads addressed input register then copies all to dac
// - code 0100 copies all inputs to dacs and leaves shutdown
// - code 1000 loads all dacs from shift data and leaves shutdown
// - code 1100 enters shutdown only while lockout_n high
// - 0010 drives user output low, 0110 drives it high
// - code 0000 changes nothing
// - 1110 selects rising-edge echo output and copies inputs to dacs
// - 1010 selects falling-edge echo output and copies inputs to dacs
// - shutdown keeps decoding words and keeps input registers
// - ctrl 11, 0100 and 1000 bring the part out of shutdown; 1110 and 1010 update dacs but do not
// - shift register msb drives serial data out for echo
// - data sampled on serial clock rising edge while select low
// - command executes on rising edge of chip select
// - echo lags 16.5 cycles in falling mode, 16 in rising mode
// - clear_n zeroes all registers, user output and serial data out
module qdac_top #(
    parameter int CODE_BITS = `QDAC_CODE_BITS,
    parameter int WORD_BITS = `QDAC_WORD_BITS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    // control pins
    input wire logic clear_n,
    input wire logic lockout_n,
    output logic user_output,
    output logic shutdown,
    output logic rising_mode,
    // dac register contents
    output logic [CODE_BITS-1:0] dac_a,
    output logic [CODE_BITS-1:0] dac_b,
    output logic [CODE_BITS-1:0] dac_c,
    output logic [CODE_BITS-1:0] dac_d
);
    localparam int CH = `QDAC_CHANNELS;

    typedef enum logic [0:0] {
        QDAC_IDLE = 1'b0,
        QDAC_SHIFT = 1'b1
    } qdac_state_t;

    // synchronised pins
    logic sclk_lvl;
    logic cs_lvl;
    logic din_lvl;
    logic clr_lvl;
    logic lock_lvl;
    qdac_pkg::qdac_edges_t sclk_e;
    qdac_pkg::qdac_edges_t cs_e;
    qdac_pkg::qdac_edges_t lock_e;

    // idle levels: clock and data low, select, clear and lockout high
    qdac_sync #(.IDLE_LEVEL(1'b0)) u_sync_sclk (.clk(clk), .rst_n(rst_n), .pin(serial_clock),
        .level(sclk_lvl), .edges(sclk_e));
    qdac_sync #(.IDLE_LEVEL(1'b1)) u_sync_cs (.clk(clk), .rst_n(rst_n), .pin(chip_select_n),
        .level(cs_lvl), .edges(cs_e));
    qdac_sync #(.IDLE_LEVEL(1'b0)) u_sync_din (.clk(clk), .rst_n(rst_n), .pin(serial_data_in),
        .level(din_lvl), .edges());
    qdac_sync #(.IDLE_LEVEL(1'b1)) u_sync_clr (.clk(clk), .rst_n(rst_n), .pin(clear_n),
        .level(clr_lvl), .edges());
    qdac_sync #(.IDLE_LEVEL(1'b1)) u_sync_lock (.clk(clk), .rst_n(rst_n), .pin(lockout_n),
        .level(lock_lvl), .edges(lock_e));

    // shift register and framing
    qdac_state_t state;
    qdac_state_t next_state;
    logic [WORD_BITS-1:0] shreg;
    logic [4:0] bit_count;
    logic word_full;
    logic echo_hold;

    wire clearing = !clr_lvl;
    wire cs_active = !cs_lvl;
    wire sample = cs_active && sclk_e.rise;
    wire [WORD_BITS-1:0] next_shreg = {shreg[WORD_BITS-2:0], din_lvl};

    always_comb begin
        next_state = state;
        case (state)
            QDAC_IDLE: if (cs_active) next_state = QDAC_SHIFT;
            QDAC_SHIFT: if (!cs_active) next_state = QDAC_IDLE;
            default: next_state = QDAC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= QDAC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // count saturates at the word length; two 8-bit bursts count the same as one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_count <= 5'h00;
        end else if (clearing || (state == QDAC_IDLE && cs_active)) begin
            bit_count <= 5'h00;
        end else if (sample && !word_full) begin
            bit_count <= bit_count + 5'h01;
        end
    end
    assign word_full = (bit_count >= 5'(WORD_BITS));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= '0;
        end else if (clearing) begin
            shreg <= '0;
        end else if (sample) begin
            shreg <= next_shreg;
        end
    end

    // msb as it stood before each shift, shown half a clock later in mode 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            echo_hold <= 1'b0;
        end else if (clearing) begin
            echo_hold <= 1'b0;
        end else if (sample) begin
            echo_hold <= shreg[WORD_BITS-1];
        end
    end

    // command decode at the end of the frame
    qdac_pkg::qdac_word_t word;
    assign word = shreg;
    wire [3:0] op = {word.addr, word.ctrl};
    wire execute = cs_e.rise && word_full && !clearing;

    wire op_load_in = (word.ctrl == 2'b01);
    wire op_load_upd = (word.ctrl == 2'b11);
    wire op_update = (op == `QDAC_OP_UPDATE);
    wire op_load_all = (op == `QDAC_OP_LOAD_ALL);
    wire op_shdn = (op == `QDAC_OP_SHDN);
    wire op_mode1 = (op == `QDAC_OP_MODE1);
    wire op_mode0 = (op == `QDAC_OP_MODE0);
    wire op_user_lo = (op == `QDAC_OP_USER_LO);
    wire op_user_hi = (op == `QDAC_OP_USER_HI);
    // code 0000 matches no decode line, so nothing moves

    wire copy_all = execute && (op_load_upd || op_update || op_mode1 || op_mode0);
    wire wake = execute && (op_update || op_load_all || op_load_upd);

    // channel registers
    logic [CODE_BITS-1:0] dac_q [CH];
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_chan
            wire named = (word.addr == 2'(g));
            qdac_chan #(.CODE_BITS(CODE_BITS)) u_chan (
                .clk(clk),
                .rst_n(rst_n),
                .clear(clearing),
                .load_input(execute && named && (op_load_in || op_load_upd)),
                .load_dac_direct(execute && op_load_all),
                .copy_input(copy_all),
                .code(word.code),
                .input_reg(),
                .dac_reg(dac_q[g])
            );
        end
    endgenerate

    // mode and control state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shutdown <= 1'b0;
            rising_mode <= 1'b0;
            user_output <= 1'b0;
        end else if (clearing) begin
            shutdown <= 1'b0;
            rising_mode <= 1'b0;
            user_output <= 1'b0;
        end else begin
            if (execute && op_shdn && lock_lvl) begin
                shutdown <= 1'b1;
            end else if (wake || lock_e.fall) begin
                shutdown <= 1'b0;
            end
            if (execute && op_mode1) begin
                rising_mode <= 1'b1;
            end else if (execute && op_mode0) begin
                rising_mode <= 1'b0;
            end
            if (execute && op_user_hi) begin
                user_output <= 1'b1;
            end else if (execute && op_user_lo) begin
                user_output <= 1'b0;
            end
        end
    end

    // echo output: mode 1 updates on rising edge, mode 0 half a cycle later
    wire echo_load = rising_mode ? sample : sclk_e.fall;
    wire echo_bit = rising_mode ? shreg[WORD_BITS-1] : echo_hold;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_out <= 1'b0;
        end else if (clearing) begin
            serial_data_out <= 1'b0;
        end else if (echo_load) begin
            serial_data_out <= echo_bit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_a <= '0;
            dac_b <= '0;
            dac_c <= '0;
            dac_d <= '0;
        end else begin
            dac_a <= dac_q[0];
            dac_b <= dac_q[1];
            dac_c <= dac_q[2];
            dac_d <= dac_q[3];
        end
    end
endmodule : qdac_top

// ---- logic/qdac_cfg.svh ----
// constants for the quad dac serial command logic
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH
`define QDAC_WORD_BITS 16
`define QDAC_CODE_BITS 10
`define QDAC_CHANNELS 4
`define QDAC_CMD_MSB 15
`define QDAC_CMD_LSB 12
`define QDAC_DATA_MSB 11
`define QDAC_DATA_LSB 2
`define QDAC_OP_IDLE 4'h0
`define QDAC_OP_USER_LO 4'h2
`define QDAC_OP_UPDATE 4'h4
`define QDAC_OP_USER_HI 4'h6
`define QDAC_OP_LOAD_ALL 4'h8
`define QDAC_OP_MODE0 4'ha
`define QDAC_OP_SHDN 4'hc
`define QDAC_OP_MODE1 4'he
`define QDAC_CODE_RESET 10'h000
`endif

// ---- logic/qdac_pkg.sv ----
// types for the quad dac serial command logic
package qdac_pkg;
    typedef struct packed {
        logic [1:0] addr;
        logic [1:0] ctrl;
        logic [9:0] code;
        logic [1:0] sub;
    } qdac_word_t;
    typedef struct packed {
        logic rise;
        logic fall;
    } qdac_edges_t;
endpackage : qdac_pkg

// ---- logic/qdac_sync.sv ----
// two-flop synchroniser with edge detection
`timescale 1ns/10ps
module qdac_sync #(
    parameter logic IDLE_LEVEL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin in, synchronised level and edges out
    input wire logic pin,
    output logic level,
    output qdac_pkg::qdac_edges_t edges
);
    logic meta;
    logic prev;
    // flops start at the pin's idle level, so reset release shows no edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= IDLE_LEVEL;
            level <= IDLE_LEVEL;
            prev <= IDLE_LEVEL;
        end else begin
            meta <= pin;
            level <= meta;
            prev <= level;
        end
    end
    // rise first, then fall, as the edge struct packs them
    assign edges = {level && !prev, !level && prev};
endmodule : qdac_sync

// ---- logic/qdac_chan.sv ----
// one channel: input register followed by dac register
`timescale 1ns/10ps
`include "qdac_cfg.svh"
module qdac_chan #(
    parameter int CODE_BITS = `QDAC_CODE_BITS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    // load controls
    input wire logic load_input,
    input wire logic load_dac_direct,
    input wire logic copy_input,
    input wire logic [CODE_BITS-1:0] code,
    // register contents
    output logic [CODE_BITS-1:0] input_reg,
    output logic [CODE_BITS-1:0] dac_reg
);
    wire [CODE_BITS-1:0] next_input = load_input ? code : input_reg;
    wire [CODE_BITS-1:0] next_dac = load_dac_direct ? code :
                                    copy_input ? next_input : dac_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_reg <= '0;
            dac_reg <= '0;
        end else if (clear) begin
            input_reg <= '0;
            dac_reg <= '0;
        end else begin
            input_reg <= next_input;
            dac_reg <= next_dac;
        end
    end
endmodule : qdac_chan

// ---- verif/qdac_top_monitor.sv ----
// assertion checker for the quad dac command logic
`timescale 1ns/10ps
module qdac_top_monitor #(
    parameter int CODE_BITS = 10,
    parameter int WORD_BITS = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    // control
    input wire logic clear_n,
    input wire logic lockout_n,
    input wire logic user_output,
    input wire logic shutdown,
    input wire logic rising_mode,
    // dac contents
    input wire logic [CODE_BITS-1:0] dac_a,
    input wire logic [CODE_BITS-1:0] dac_b,
    input wire logic [CODE_BITS-1:0] dac_c,
    input wire logic [CODE_BITS-1:0] dac_d
);
    wire logic [4*CODE_BITS-1:0] dacs = {dac_a, dac_b, dac_c, dac_d};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_CLEAR: assert property ((!clear_n)[*6] |-> dacs == '0 && !user_output
        && !serial_data_out)
        else $error("clear left outputs set");
    AST_RESET: assert property ($rose(rst_n) |-> dacs == '0 && !shutdown && !user_output
        && !rising_mode)
        else $error("outputs not zero after reset");
    AST_DAC_HOLD: assert property ((!chip_select_n && clear_n)[*8] |-> $stable(dacs))
        else $error("dac changed inside a frame");
    AST_CTRL_HOLD: assert property ((!chip_select_n && clear_n)[*8]
        |-> $stable({user_output, rising_mode}))
        else $error("control output changed inside a frame");
    AST_LOCKOUT: assert property ((!lockout_n)[*8] |-> !shutdown)
        else $error("shutdown while locked out");
    AST_SHDN_ENTER: assert property ($rose(shutdown) |-> chip_select_n && lockout_n)
        else $error("shutdown entered outside command");
    AST_SHDN_LEAVE: assert property ($fell(shutdown) && lockout_n && clear_n
        |-> chip_select_n)
        else $error("shutdown left inside a frame");
    AST_ECHO_IDLE: assert property ((chip_select_n && !serial_clock && clear_n)[*8]
        |-> $stable(serial_data_out))
        else $error("echo moved without serial clock");
    AST_USER_CMD: assert property ($changed(user_output) && clear_n
        |-> chip_select_n)
        else $error("user output changed inside a frame");
    cover property ($rose(shutdown));
    cover property ($rose(rising_mode));
    cover property ($rose(user_output));
endmodule : qdac_top_monitor

// ---- verif/qdac_host.sv ----
// host model: serial bus master driving the link
`timescale 1ns/10ps
module qdac_host (
    // clock
    input wire logic clk,
    // link
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // n bits msb first; split pauses the clock after the first byte
    task automatic send(input logic [15:0] w, input int n, input bit split, output logic [15:0] echo);
        echo = 16'h0;
        chip_select_n <= 1'b0;
        tick(8);
        for (int i = 15; i > 15 - n; i--) begin
            serial_data_in <= w[i];
            tick(8);
            serial_clock <= 1'b1;
            tick(8);
            // echo read at the end of the high phase, which tells the two modes apart
            echo = {echo[14:0], serial_data_out};
            serial_clock <= 1'b0;
            if (split && i == 8) tick(16);
        end
        tick(2);
        chip_select_n <= 1'b1;
        serial_data_in <= ~serial_data_in;
        tick(24);
    endtask : send
endmodule : qdac_host

// ---- verif/qdac_top_tb_top.sv ----
// self-checking bench for the quad dac command logic
`timescale 1ns/10ps
module qdac_top_tb_top;
    typedef struct {logic [15:0] w; logic [42:0] e;} qdac_row_t;
    logic clk = 1'b0, rst_n = 1'b0, clear_n = 1'b1, lockout_n = 1'b1;
    logic sclk, cs_n, sdi, sdo, user_output, shutdown, rising_mode;
    logic [9:0] dac_a, dac_b, dac_c, dac_d;
    logic [15:0] echo;
    int num_errors = 0, checks = 0, cycles = 0;
    wire logic [42:0] obs = {dac_a, dac_b, dac_c, dac_d, user_output, shutdown, rising_mode};
    localparam logic [39:0] IN4 = {10'h155, 10'h2aa, 10'h0f0, 10'h000};
    qdac_row_t rows[12] = '{
        '{16'h1554, {40'h0, 3'b000}}, '{16'h5aa8, {40'h0, 3'b000}},
        '{16'hb3c0, {IN4, 3'b000}}, '{16'h6000, {IN4, 3'b100}},
        '{16'h8ffc, {{4{10'h3ff}}, 3'b100}}, '{16'hc000, {{4{10'h3ff}}, 3'b110}},
        '{16'h4000, {IN4, 3'b100}}, '{16'he000, {IN4, 3'b101}},
        '{16'hd004, {IN4, 3'b101}}, '{16'ha000, {IN4[39:10], 10'h001, 3'b100}},
        '{16'h2000, {IN4[39:10], 10'h001, 3'b000}}, '{16'h0ffc, {IN4[39:10], 10'h001, 3'b000}}};
    always #2.5 clk = ~clk;
    qdac_host i_host (.clk(clk), .serial_clock(sclk), .chip_select_n(cs_n),
        .serial_data_in(sdi), .serial_data_out(sdo));
    qdac_top i_dut (.clk(clk), .rst_n(rst_n), .serial_clock(sclk), .chip_select_n(cs_n),
        .serial_data_in(sdi), .serial_data_out(sdo), .clear_n(clear_n), .lockout_n(lockout_n),
        .user_output(user_output), .shutdown(shutdown), .rising_mode(rising_mode),
        .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c), .dac_d(dac_d));
    task automatic chk(input logic [42:0] exp, input logic [42:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        i_host.tick(4);
        rst_n <= 1'b1;
        i_host.tick(6);
        chk(43'h0, obs);
        foreach (rows[i]) begin
            i_host.send(rows[i].w, 16, i[0], echo);
            chk(rows[i].e, obs);
        end
        i_host.send(16'h8000, 12, 1'b0, echo);
        chk(rows[11].e, obs);
        lockout_n <= 1'b0;
        i_host.send(16'hc000, 16, 1'b0, echo);
        chk(rows[11].e, obs);
        lockout_n <= 1'b1;
        i_host.send(16'hc000, 16, 1'b0, echo);
        i_host.send(16'h02a8, 16, 1'b0, echo); // code 0000 leaves shutdown as is
        i_host.send(16'h10a8, 16, 1'b1, echo);
        chk({rows[11].e[42:1], 1'b0} | 43'h2, obs);
        i_host.send(16'h4000, 16, 1'b0, echo);
        chk({10'h02a, IN4[29:10], 10'h001, 3'b000}, obs);
        // lockout falling while shut down wakes without touching the dacs
        i_host.send(16'hc000, 16, 1'b0, echo);
        chk({10'h02a, IN4[29:10], 10'h001, 3'b010}, obs);
        lockout_n <= 1'b0;
        i_host.tick(10);
        chk({10'h02a, IN4[29:10], 10'h001, 3'b000}, obs);
        lockout_n <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            i_host.send(m ? 16'he000 : 16'ha000, 16, 1'b0, echo);
            i_host.send(16'h0abc, 16, 1'b0, echo);
            i_host.send(16'h0000, 16, 1'b0, echo);
            // mode 0 trails half a bit more, so its first bit is the older word's lsb
            chk({27'h0, m ? 16'h0abc : 16'h055e}, {27'h0, echo});
        end
        i_host.send(16'h6000, 16, 1'b0, echo);
        clear_n <= 1'b0;
        i_host.tick(10);
        chk(43'h0, obs);
        chk(43'h0, {42'h0, sdo});
        clear_n <= 1'b1;
        i_host.tick(6);
        tally_and_finish();
    end
endmodule : qdac_top_tb_top
bind qdac_top qdac_top_monitor #(.CODE_BITS(CODE_BITS), .WORD_BITS(WORD_BITS)) i_mon (.clk(clk),
    .rst_n(rst_n), .serial_clock(serial_clock), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .clear_n(clear_n),
    .lockout_n(lockout_n), .user_output(user_output), .shutdown(shutdown),
    .rising_mode(rising_mode), .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c), .dac_d(dac_d));
